// File: logic/ssc_atn_ctrl.sv
// latched attention drive, set by automatic sources
`timescale 1ns/1ns

module ssc_atn_ctrl (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] set_req,
   input  wire logic       clear,
   output logic            atn
);

   // set wins over clear; enable bits are not inputs, so dropping them cannot release
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         atn <= 1'b0;
      else if (|set_req)
         atn <= 1'b1;
      else if (clear)
         atn <= 1'b0; // RL17
   end

   atn_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      atn && !clear |=> atn) // RL17
      else $error("attention released without a clear");

endmodule // ssc_atn_ctrl

// File: logic/ssc_pkg.sv
// types shared by the sequence control block
package ssc_pkg;

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'h0,
      ST_DRIVE = 2'h1,
      ST_WAIT  = 2'h3,
      ST_DONE  = 2'h2
   } ssc_state_type;

   typedef struct packed
   {
      logic       bsy;
      logic       sel;
      logic       atn;
      logic       rst;
      logic       msg;
      logic       cd;
      logic       io;
      logic [7:0] data;
      logic       parity_err;
   } ssc_bus_in_type;

   typedef struct packed
   {
      logic       sel;
      logic       sel_oe;
      logic       bsy;
      logic       bsy_oe;
      logic       io;
      logic       io_oe;
      logic       atn;
      logic       atn_oe;
      logic       rst;
      logic       rst_oe;
      logic [7:0] data;
      logic       data_oe;
   } ssc_bus_out_type;

   typedef struct packed
   {
      logic       selection_timer_enable;
      logic [1:0] selection_timeout_select;
      logic       bus_parity_check_enable;
      logic       attention_clear;
      logic       clear_done;
      logic       clear_timeout;
      logic       clear_selected;
      logic [2:0] own_id_field;
      logic [2:0] peer_id_field;
   } ssc_side_ctl_type;

   typedef struct packed
   {
      logic selecting_in_progress;
      logic selection_done_flag;
      logic selection_timeout_flag;
      logic selected_in_flag;
      logic target_status;
   } ssc_status_type;

endpackage

// File: logic/ssc_regs.svh
// offsets, bit positions, reset values and timing counts of the sequence control block
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

`define SSC_SEQ_CTRL_OFFSET   8'h00
`define SSC_SEQ_CTRL_RESET    8'h00
`define SSC_BIT_TARGET_ROLE   7
`define SSC_BIT_SEL_OUT       6
`define SSC_BIT_SEL_IN        5
`define SSC_BIT_RESEL_IN      4
`define SSC_BIT_ATN_OUT       3
`define SSC_BIT_ATN_IN        2
`define SSC_BIT_ATN_PARITY    1
`define SSC_BIT_RST_OUT       0

`define SSC_CLK_PERIOD_NS     40
`define SSC_SELECTION_TIMEOUT_FLAG_256_MS      256
`define SSC_SELECTION_TIMEOUT_FLAG_128_MS      128
`define SSC_SELECTION_TIMEOUT_FLAG_64_MS       64
`define SSC_SELECTION_TIMEOUT_FLAG_32_MS       32
`define SSC_MS_TO_CYCLES(ms)  ((ms) * 1000000 / `SSC_CLK_PERIOD_NS)
`define SSC_SELECTION_TIMEOUT_FLAG_CNT_W       23

`endif

// File: logic/ssc_sel_timer.sv
// hardware selection timeout counter
`timescale 1ns/1ns
`include "ssc_regs.svh"

module ssc_sel_timer #(
   parameter int unsigned CYC_256 = `SSC_MS_TO_CYCLES(`SSC_SELECTION_TIMEOUT_FLAG_256_MS),
   parameter int unsigned CYC_128 = `SSC_MS_TO_CYCLES(`SSC_SELECTION_TIMEOUT_FLAG_128_MS),
   parameter int unsigned CYC_64  = `SSC_MS_TO_CYCLES(`SSC_SELECTION_TIMEOUT_FLAG_64_MS),
   parameter int unsigned CYC_32  = `SSC_MS_TO_CYCLES(`SSC_SELECTION_TIMEOUT_FLAG_32_MS)
) (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic [1:0] select,
   output logic            expired
);

   logic [`SSC_SELECTION_TIMEOUT_FLAG_CNT_W-1:0] count;

   function automatic logic [`SSC_SELECTION_TIMEOUT_FLAG_CNT_W-1:0] limit(input logic [1:0] sel);
      unique case (sel)
         2'h0: limit = `SSC_SELECTION_TIMEOUT_FLAG_CNT_W'(CYC_256 - 1);
         2'h1: limit = `SSC_SELECTION_TIMEOUT_FLAG_CNT_W'(CYC_128 - 1);
         2'h2: limit = `SSC_SELECTION_TIMEOUT_FLAG_CNT_W'(CYC_64 - 1);
         2'h3: limit = `SSC_SELECTION_TIMEOUT_FLAG_CNT_W'(CYC_32 - 1);
      endcase
   endfunction

   // restart on every new wait so a stale count never shortens the next one
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count   <= '0;
         expired <= 1'b0;
      end
      else if (!run)
      begin
         count   <= '0;
         expired <= 1'b0;
      end
      else if (count == limit(select))
         expired <= 1'b1; // RL22
      else
         count <= count + `SSC_SELECTION_TIMEOUT_FLAG_CNT_W'(1);
   end

   timeout_period_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(expired) |-> $past(count) == limit($past(select))) // RL22
      else $error("selection timeout fired at the wrong count");

endmodule // ssc_sel_timer

// File: logic/ssc_seq_ctrl.sv
// sequence control register with selection, reselection, attention and bus reset sequences
//
// Contract
// (RL1) each set enable bit lets its hardware sequence run; clear bit disables it
// (RL2) sequence control register reads back its current contents
// (RL3) bus reset clears all register bits except the reset-out bit
// (RL4) bits with zero reset value are cleared while chip reset is asserted
// (RL5) select-out with initiator role runs selection using own and peer ids
// (RL6) select-out with target role runs reselection using own and peer ids
// (RL7) selecting-in-progress flag is set while waiting for busy from the peer
// (RL8) sequencer waits for done or timeout flag, or times out itself
// (RL9) select-out enable returns to zero only by write or chip reset; a bus reset also clears it here
// (RL10) select-in enabled: answer selection, set selected-in and target status
// (RL11) sequencer keeps select-in enabled until it writes it to zero; a bus reset also clears it here
// (RL12) reselect-in enabled: answer reselection, set selected-in, clear target status
// (RL13) reselect-in enable is cleared only by writing zero to it; a bus reset also clears it here
// (RL14) auto attention out asserts ATN during an initiator selection
// (RL15) auto attention in asserts ATN when reselected by a target
// (RL16) auto attention parity asserts ATN on parity error in input phases
// (RL17) automatic ATN is released only by attention clear or bus free
// (RL18) writing zero to an auto attention bit leaves ATN unchanged
// (RL19) reset-out bit set drives bus RST regardless of role
// (RL20) sequencer removes bus reset by writing zero to reset-out
// (RL21) timer on: timeout drops SEL and sets flag; off: SEL stays
// (RL22) timeout select 00/01/10/11 gives 256/128/64/32 ms
// (RL23) register bits 7..0: role, sel out, sel in, resel in, atn out/in/parity, rst out
`timescale 1ns/1ns
`include "ssc_regs.svh"

module ssc_seq_ctrl #(
   parameter int unsigned SEL_TO_256_CYCLES = `SSC_MS_TO_CYCLES(`SSC_SELECTION_TIMEOUT_FLAG_256_MS),
   parameter int unsigned SEL_TO_128_CYCLES = `SSC_MS_TO_CYCLES(`SSC_SELECTION_TIMEOUT_FLAG_128_MS),
   parameter int unsigned SEL_TO_64_CYCLES  = `SSC_MS_TO_CYCLES(`SSC_SELECTION_TIMEOUT_FLAG_64_MS),
   parameter int unsigned SEL_TO_32_CYCLES  = `SSC_MS_TO_CYCLES(`SSC_SELECTION_TIMEOUT_FLAG_32_MS)
) (
   input  wire logic                      sys_clk,
   input  wire logic                      rst_b,
   input  wire logic [7:0]                seq_addr,
   input  wire logic                      seq_wr,
   input  wire logic [7:0]                seq_wdata,
   output logic [7:0]                     seq_rdata,
   input  wire ssc_pkg::ssc_side_ctl_type side_ctl,
   input  wire ssc_pkg::ssc_bus_in_type   bus_in,
   output ssc_pkg::ssc_bus_out_type       bus_out,
   output ssc_pkg::ssc_status_type        status
);

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ----------------------------------------
   // sequence control register
   // ----------------------------------------
   logic [7:0] sequence_control_reg;
   logic       wr_hit;
   logic       target_role_select;
   logic       select_out_enable;
   logic       select_in_enable;
   logic       reselect_in_enable;
   logic       auto_attention_out;
   logic       auto_attention_in;
   logic       auto_attention_parity;
   logic       bus_reset_out;

   function automatic logic [7:0] id_bit(input logic [2:0] id);
      id_bit = 8'h01 << id;
   endfunction

   assign wr_hit                = seq_wr && (seq_addr == `SSC_SEQ_CTRL_OFFSET);
   assign target_role_select    = sequence_control_reg[`SSC_BIT_TARGET_ROLE]; // RL23
   assign select_out_enable     = sequence_control_reg[`SSC_BIT_SEL_OUT];
   assign select_in_enable      = sequence_control_reg[`SSC_BIT_SEL_IN];
   assign reselect_in_enable    = sequence_control_reg[`SSC_BIT_RESEL_IN];
   assign auto_attention_out    = sequence_control_reg[`SSC_BIT_ATN_OUT];
   assign auto_attention_in     = sequence_control_reg[`SSC_BIT_ATN_IN];
   assign auto_attention_parity = sequence_control_reg[`SSC_BIT_ATN_PARITY];
   assign bus_reset_out         = sequence_control_reg[`SSC_BIT_RST_OUT];

   // hardware never clears an enable on its own, only writes and resets do
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         sequence_control_reg <= `SSC_SEQ_CTRL_RESET; // RL4
      else if (bus_in.rst)
         sequence_control_reg <= {7'h00, wr_hit ? seq_wdata[`SSC_BIT_RST_OUT] : bus_reset_out}; // RL3
      else if (wr_hit)
         sequence_control_reg <= seq_wdata; // RL9 RL13
   end

   // read data is one cycle behind the address; unmapped offsets read zero
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         seq_rdata <= 8'h00;
      else if (seq_addr == `SSC_SEQ_CTRL_OFFSET)
         seq_rdata <= sequence_control_reg; // RL2
      else
         seq_rdata <= 8'h00;
   end

   // ----------------------------------------
   // selection / reselection out
   // ----------------------------------------
   ssc_pkg::ssc_state_type state;
   ssc_pkg::ssc_state_type next_state;
   logic                   bus_free;
   logic                   timer_expired;
   logic                   sel_drv;
   logic                   bsy_drv;
   logic                   io_drv;
   logic [7:0]             data_drv;
   logic                   selecting_in_progress;
   logic                   selection_done_flag;
   logic                   selection_timeout_flag;
   logic                   peer_answered;
   logic                   timed_out;

   assign bus_free      = !bus_in.bsy && !bus_in.sel;
   assign peer_answered = (state == ssc_pkg::ST_WAIT) && bus_in.bsy && select_out_enable;
   assign timed_out     = (state == ssc_pkg::ST_WAIT) && timer_expired && !bus_in.bsy && select_out_enable;

   always_comb
   begin
      next_state = state;
      unique case (state)
         ssc_pkg::ST_IDLE:
            if (select_out_enable && bus_free)
               next_state = ssc_pkg::ST_DRIVE; // RL1
         ssc_pkg::ST_DRIVE:
            next_state = ssc_pkg::ST_WAIT;
         ssc_pkg::ST_WAIT:
            if (!select_out_enable)
               next_state = ssc_pkg::ST_IDLE;
            else if (bus_in.bsy || timer_expired)
               next_state = ssc_pkg::ST_DONE;
         ssc_pkg::ST_DONE:
            if (!select_out_enable)
               next_state = ssc_pkg::ST_IDLE;
      endcase
      if (bus_in.rst)
         next_state = ssc_pkg::ST_IDLE;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= ssc_pkg::ST_IDLE;
      else
         state <= next_state;
   end

   // sel held through the wait; with the timer off only the peer's BSY, the sequencer or a bus reset ends it
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_drv  <= 1'b0;
         io_drv   <= 1'b0;
         data_drv <= 8'h00;
      end
      else
      begin
         sel_drv  <= (next_state == ssc_pkg::ST_DRIVE) || (next_state == ssc_pkg::ST_WAIT); // RL21
         io_drv   <= ((next_state == ssc_pkg::ST_DRIVE) || (next_state == ssc_pkg::ST_WAIT))
                     && target_role_select; // RL6
         data_drv <= id_bit(side_ctl.own_id_field) | id_bit(side_ctl.peer_id_field); // RL5 RL6
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         selecting_in_progress <= 1'b0;
      else
         selecting_in_progress <= (next_state == ssc_pkg::ST_WAIT); // RL7
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         selection_done_flag    <= 1'b0;
         selection_timeout_flag <= 1'b0;
      end
      else
      begin
         if (peer_answered)
            selection_done_flag <= 1'b1; // RL5
         else if (side_ctl.clear_done)
            selection_done_flag <= 1'b0;
         if (timed_out)
            selection_timeout_flag <= 1'b1; // RL21
         else if (side_ctl.clear_timeout)
            selection_timeout_flag <= 1'b0;
      end
   end

   ssc_sel_timer #(
      .CYC_256 (SEL_TO_256_CYCLES),
      .CYC_128 (SEL_TO_128_CYCLES),
      .CYC_64  (SEL_TO_64_CYCLES),
      .CYC_32  (SEL_TO_32_CYCLES)
   ) u_timer (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .run     ((state == ssc_pkg::ST_WAIT) && side_ctl.selection_timer_enable),
      .select  (side_ctl.selection_timeout_select),
      .expired (timer_expired)
   );

   // ----------------------------------------
   // selection / reselection in
   // ----------------------------------------
   logic [7:0] own_bit;
   logic       valid_sel;
   logic       sel_hit;
   logic       resel_hit;
   logic       resp_bsy;
   logic       next_resp_bsy;
   logic       bsy_oe;
   logic       selected_in_flag;
   logic       target_status;

   // a valid phase carries our id plus at least one other, with no parity fault when checked
   assign own_bit   = id_bit(side_ctl.own_id_field);
   assign valid_sel = (state == ssc_pkg::ST_IDLE) && !resp_bsy && bus_in.sel && !bus_in.bsy
                      && |(bus_in.data & own_bit) && |(bus_in.data & ~own_bit)
                      && !(side_ctl.bus_parity_check_enable && bus_in.parity_err);
   assign sel_hit   = valid_sel && !bus_in.io && select_in_enable; // RL10
   assign resel_hit = valid_sel && bus_in.io && reselect_in_enable; // RL12

   always_comb
   begin
      next_resp_bsy = resp_bsy;
      if (bus_in.rst)
         next_resp_bsy = 1'b0;
      else if (sel_hit || resel_hit)
         next_resp_bsy = 1'b1;
      else if (side_ctl.clear_selected)
         next_resp_bsy = 1'b0;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         resp_bsy <= 1'b0;
         bsy_oe   <= 1'b0;
      end
      else
      begin
         resp_bsy <= next_resp_bsy;
         bsy_oe   <= (next_state == ssc_pkg::ST_DRIVE) || next_resp_bsy;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         selected_in_flag <= 1'b0;
         target_status    <= 1'b0;
      end
      else
      begin
         if (sel_hit || resel_hit)
            selected_in_flag <= 1'b1; // RL10 RL12
         else if (side_ctl.clear_selected)
            selected_in_flag <= 1'b0;
         if (sel_hit)
            target_status <= 1'b1; // RL10
         else if (resel_hit)
            target_status <= 1'b0; // RL12
      end
   end

   // ----------------------------------------
   // attention and bus reset
   // ----------------------------------------
   logic [2:0] atn_set;
   logic       atn_q;
   logic       input_phase;
   logic       rst_oe;

   // data in and message in both have io set and cd equal to msg
   assign input_phase = bus_in.io && (bus_in.cd == bus_in.msg) && bus_in.bsy;
   assign atn_set[0]  = auto_attention_out && !target_role_select
                        && (state == ssc_pkg::ST_DRIVE); // RL14
   assign atn_set[1]  = auto_attention_in && resel_hit; // RL15
   assign atn_set[2]  = auto_attention_parity && side_ctl.bus_parity_check_enable
                        && !target_role_select && !target_status
                        && input_phase && bus_in.parity_err; // RL16

   ssc_atn_ctrl u_atn (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .set_req (atn_set),
      .clear   (side_ctl.attention_clear || bus_free), // RL17 RL18
      .atn     (atn_q)
   );

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_oe <= 1'b0;
      else
         rst_oe <= bus_reset_out; // RL19 RL20
   end

   // ----------------------------------------
   // outputs, all open-drain except data: level equals enable
   // ----------------------------------------
   assign bus_out = '{sel: sel_drv, sel_oe: sel_drv, bsy: bsy_oe, bsy_oe: bsy_oe,
                      io: io_drv, io_oe: io_drv, atn: atn_q, atn_oe: atn_q,
                      rst: rst_oe, rst_oe: rst_oe, data: data_drv, data_oe: sel_drv};
   assign status  = '{selecting_in_progress: selecting_in_progress,
                      selection_done_flag: selection_done_flag,
                      selection_timeout_flag: selection_timeout_flag,
                      selected_in_flag: selected_in_flag,
                      target_status: target_status};

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   readback_a: assert property ( // RL2
      wr_hit && !bus_in.rst ##1 (seq_addr == `SSC_SEQ_CTRL_OFFSET) && !bus_in.rst && !wr_hit
      |=> seq_rdata == $past(seq_wdata, 2))
      else $error("register readback differs from written value");

   bus_reset_keep_a: assert property ( // RL3
      bus_in.rst && !wr_hit |=> sequence_control_reg == {7'h00, $past(bus_reset_out)})
      else $error("bus reset did not clear the enables");

   chip_reset_zero_a: assert property (disable iff (1'b0) // RL4
      $rose(rst_n) |-> sequence_control_reg == 8'h00 && !bus_out.rst_oe && !bus_out.sel_oe)
      else $error("register not zero after chip reset");

   sel_start_a: assert property (disable iff (!rst_n || bus_in.rst) // RL5
      state == ssc_pkg::ST_IDLE && select_out_enable && bus_free
      |=> bus_out.sel_oe && bus_out.bsy_oe && bus_out.data == (own_bit | id_bit(side_ctl.peer_id_field))
      ##1 !bus_out.bsy_oe && status.selecting_in_progress) // RL7
      else $error("selection out did not start correctly");

   resel_io_a: assert property ( // RL6
      state == ssc_pkg::ST_WAIT |-> bus_out.io_oe == target_role_select)
      else $error("io drive does not follow role bit");

   sel_done_a: assert property ( // RL5
      peer_answered && !bus_in.rst |=> status.selection_done_flag && !bus_out.sel_oe)
      else $error("answered selection not completed");

   timeout_drop_a: assert property ( // RL21
      timed_out && !bus_in.rst |=> !bus_out.sel_oe && status.selection_timeout_flag)
      else $error("timeout did not drop sel");

   sel_hold_a: assert property ( // RL21
      state == ssc_pkg::ST_WAIT && !bus_in.bsy && select_out_enable && !timer_expired && !bus_in.rst
      |=> bus_out.sel_oe)
      else $error("sel released without cause");

   select_in_a: assert property ( // RL10
      sel_hit && !bus_in.rst |=> status.selected_in_flag && status.target_status && bus_out.bsy_oe)
      else $error("selection in not answered");

   reselect_in_a: assert property ( // RL12
      resel_hit && !bus_in.rst |=> status.selected_in_flag && !status.target_status
      ##0 (bus_out.atn_oe || !$past(auto_attention_in))) // RL15
      else $error("reselection in not answered");

   atn_hold_a: assert property ( // RL18
      bus_out.atn_oe && !side_ctl.attention_clear && !bus_free |=> bus_out.atn_oe)
      else $error("attention dropped without clear or bus free");

   parity_atn_a: assert property ( // RL16
      atn_set[2] |=> bus_out.atn_oe)
      else $error("parity error did not raise attention");

   rst_out_a: assert property ( // RL19
      wr_hit && seq_wdata[`SSC_BIT_RST_OUT] |=> ##1 bus_out.rst_oe)
      else $error("reset out not driven");

   sel_done_c:   cover property (peer_answered);
   timeout_c:    cover property (timed_out);
   select_in_c:  cover property (sel_hit);
   resel_atn_c:  cover property (resel_hit && auto_attention_in);

endmodule // ssc_seq_ctrl

// File: verif/ssc_bus_peer.sv
// far-side bus device model: answers selections and starts its own
`timescale 1ns/1ns

module ssc_bus_peer (
   input  wire logic                     sys_clk,
   input  wire ssc_pkg::ssc_bus_out_type dev,
   input  wire logic                     answer,
   input  wire logic [3:0]               delay,
   input  wire logic                     sel_go,
   input  wire logic                     sel_io,
   input  wire logic [7:0]               sel_id,
   input  wire logic                     perr,
   output ssc_pkg::ssc_bus_in_type       bus
);
   logic [3:0] wait_cnt = 4'h0;
   logic       peer_bsy = 1'b0;
   logic       peer_sel = 1'b0;

   // answer BSY only after the chosen delay, so slow targets are covered
   always_ff @(posedge sys_clk)
   begin
      wait_cnt <= (dev.sel_oe && answer) ? wait_cnt + 4'h1 : 4'h0;
      if (!answer)
         peer_bsy <= 1'b0;
      else if (dev.sel_oe && wait_cnt == delay)
         peer_bsy <= 1'b1;
      peer_sel <= sel_go && !dev.bsy_oe;
   end

   // terminated lines: anything released reads deasserted
   always_comb
   begin
      bus      = '0;
      bus.bsy  = dev.bsy_oe | peer_bsy;
      bus.sel  = dev.sel_oe | peer_sel;
      bus.atn  = dev.atn_oe;
      bus.rst  = dev.rst_oe;
      bus.io   = dev.io_oe | (sel_io & (peer_sel | perr));
      bus.parity_err = perr;
      bus.data = (dev.data_oe ? dev.data : 8'h00) | (peer_sel ? sel_id : 8'h00);
   end
endmodule // ssc_bus_peer

// File: verif/test_scsi_selection_sequence_control.sv
// self-checking bench for the sequence control block
`timescale 1ns/1ns

module test_scsi_selection_sequence_control;
   logic                      sys_clk = 1'b0;
   logic                      rst_b = 1'b0;
   logic [7:0]                seq_addr = 8'h00;
   logic                      seq_wr = 1'b0;
   logic [7:0]                seq_wdata = 8'h00;
   logic [7:0]                seq_rdata;
   ssc_pkg::ssc_side_ctl_type side_ctl = '0;
   ssc_pkg::ssc_bus_in_type   bus_in;
   ssc_pkg::ssc_bus_out_type  bus_out;
   ssc_pkg::ssc_status_type   status;
   logic                      answer = 1'b0;
   logic                      sel_go = 1'b0;
   logic                      sel_io = 1'b0;
   logic                      perr = 1'b0;
   logic [7:0]                sel_id = 8'h81;
   int                        errors = 0;
   int                        check_count = 0;
   logic [7:0]                q;

   always #20 sys_clk = ~sys_clk;

   ssc_seq_ctrl #(.SEL_TO_256_CYCLES(40), .SEL_TO_128_CYCLES(20), .SEL_TO_64_CYCLES(10),
                  .SEL_TO_32_CYCLES(5)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .seq_addr(seq_addr), .seq_wr(seq_wr), .seq_wdata(seq_wdata), .seq_rdata(seq_rdata),
      .side_ctl(side_ctl), .bus_in(bus_in), .bus_out(bus_out), .status(status));

   ssc_bus_peer u_peer (.sys_clk(sys_clk), .dev(bus_out), .answer(answer), .delay(4'h3),
      .sel_go(sel_go), .sel_io(sel_io), .sel_id(sel_id), .perr(perr), .bus(bus_in));

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1 seq_addr = a;
      seq_wdata = d;
      seq_wr = 1'b1;
      @(posedge sys_clk);
      #1 seq_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      seq_addr = a;
      repeat (2) @(posedge sys_clk);
      #1 q = seq_rdata;
   endtask

   // bounded wait on one status bit, counting the cycles spent
   task automatic wait_flag(input int b, output int n);
      for (n = 0; n < 60 && status[b] !== 1'b1; n++)
      begin
         @(posedge sys_clk);
         #1;
      end
      chk("status flag", 8'h01, {7'h00, status[b]});
   endtask

   task automatic clr_all;
      {side_ctl.clear_done, side_ctl.clear_timeout, side_ctl.clear_selected} = 3'b111;
      @(posedge sys_clk);
      #1 {side_ctl.clear_done, side_ctl.clear_timeout, side_ctl.clear_selected} = 3'b000;
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic reg_access;
      rd(8'h00);
      chk("reset value", 8'h00, q);
      wr(8'h00, 8'hB4);
      rd(8'h00);
      chk("readback", 8'hB4, q);
      rd(8'h05);
      chk("unmapped read", 8'h00, q);
      wr(8'h00, 8'hB5);
      repeat (4) @(posedge sys_clk);
      #1 rd(8'h00);
      chk("bus reset keeps bit 0", 8'h01, q);
      chk("rst out", 8'h01, {7'h00, bus_out.rst_oe});
      wr(8'h00, 8'h00);
      repeat (2) @(posedge sys_clk);
      #1 chk("rst released", 8'h00, {7'h00, bus_out.rst_oe});
   endtask

   task automatic select_out;
      int n;
      answer = 1'b1;
      wr(8'h00, 8'h48);
      wait_flag(4, n);
      chk("id bits", 8'h84, bus_out.data);
      chk("initiator io", 8'h00, {7'h00, bus_out.io_oe});
      chk("auto atn out", 8'h01, {7'h00, bus_out.atn_oe});
      wait_flag(3, n);
      @(posedge sys_clk);
      #1 chk("sel dropped", 8'h00, {7'h00, bus_out.sel_oe});
      side_ctl.attention_clear = 1'b1;
      @(posedge sys_clk);
      #1 side_ctl.attention_clear = 1'b0;
      @(posedge sys_clk);
      #1 chk("atn cleared", 8'h00, {7'h00, bus_out.atn_oe});
      wr(8'h00, 8'h00);
      answer = 1'b0;
      clr_all;
   endtask

   task automatic reselect_timeout;
      int n;
      side_ctl.selection_timer_enable = 1'b1;
      side_ctl.selection_timeout_select = 2'b11;
      wr(8'h00, 8'hC0);
      wait_flag(4, n);
      chk("target io", 8'h01, {7'h00, bus_out.io_oe});
      wait_flag(2, n);
      chk("32 ms count", 8'h01, {7'h00, n >= 3 && n <= 7});
      @(posedge sys_clk);
      #1 chk("sel off", 8'h00, {7'h00, bus_out.sel_oe});
      wr(8'h00, 8'h00);
      side_ctl.selection_timer_enable = 1'b0;
      clr_all;
   endtask

   task automatic select_in(input logic io, input logic [7:0] ctl);
      int n;
      sel_io = io;
      wr(8'h00, ctl);
      sel_go = 1'b1;
      wait_flag(1, n);
      chk("answer bsy", 8'h01, {7'h00, bus_out.bsy_oe});
      chk("target flag", {7'h00, !io}, {7'h00, status[0]});
      sel_go = 1'b0;
   endtask

   task automatic selection_in_cases;
      select_in(1'b0, 8'h20);
      clr_all;
      wr(8'h00, 8'h00);
      select_in(1'b1, 8'h14);
      chk("auto atn in", 8'h01, {7'h00, bus_out.atn_oe});
      wr(8'h00, 8'h10);
      repeat (2) @(posedge sys_clk);
      #1 chk("atn kept", 8'h01, {7'h00, bus_out.atn_oe});
      {side_ctl.bus_parity_check_enable, side_ctl.attention_clear} = 2'b11;
      wr(8'h00, 8'h12);
      chk("atn clear pulse", 8'h00, {7'h00, bus_out.atn_oe});
      side_ctl.attention_clear = 1'b0;
      perr = 1'b1;
      @(posedge sys_clk);
      #1 perr = 1'b0;
      chk("parity atn", 8'h01, {7'h00, bus_out.atn_oe});
      clr_all;
      repeat (2) @(posedge sys_clk);
      #1 chk("bus free atn", 8'h00, {7'h00, bus_out.atn_oe});
      wr(8'h00, 8'h00);
   endtask

   initial
   begin
      side_ctl.own_id_field = 3'h7;
      side_ctl.peer_id_field = 3'h2;
      repeat (6) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 reg_access;
      select_out;
      reselect_timeout;
      selection_in_cases;
      tally_and_finish;
   end

   initial
   begin
      #(40 * 3000);
      errors++;
      tally_and_finish;
   end
endmodule // test_scsi_selection_sequence_control
